// File: design/caw_pkg.sv
// Purpose: Shared constants and types for the CPU address alias router
// Assumes: One clock, whole-word accesses only
// Notes:   Register offsets are byte addresses on the AHB-Lite slave
package caw_pkg;
  // Write buffer geometry
  localparam int          FIFO_DEPTH  = 4;
  localparam int          PTR_W       = 2;
  localparam int          CNT_W       = 3;
  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_SRAM    = 8'h04;
  localparam logic [7:0]  OFF_B0_BASE = 8'h08;
  localparam logic [7:0]  OFF_B0_SIZE = 8'h0c;
  localparam logic [7:0]  OFF_B1_BASE = 8'h10;
  localparam logic [7:0]  OFF_B1_SIZE = 8'h14;
  localparam logic [7:0]  OFF_BANK_EN = 8'h18;
  localparam logic [7:0]  OFF_STATUS  = 8'h1c;
  // Field positions
  localparam int          WB_EN_BIT   = 3;
  localparam int          ST_STALL    = 0;
  localparam int          ST_BUSY     = 1;
  localparam int          ST_CNT      = 2;
  localparam int          ST_BOOT     = 8;
  // SRAM size codes and byte counts
  localparam logic [1:0]  SRAM_32K    = 2'h0;
  localparam logic [1:0]  SRAM_64K    = 2'h1;
  localparam logic [31:0] BYTES_32K   = 32'h0000_8000;
  localparam logic [31:0] BYTES_64K   = 32'h0001_0000;
  localparam logic [31:0] BYTES_96K   = 32'h0001_8000;
  // Address windows: top six bits pick a 64 MB window
  localparam logic [5:0]  WIN_TCM     = 6'h01;
  localparam logic [3:0]  NIB_BUF     = 4'h4;
  localparam logic [3:0]  NIB_NBUF    = 4'h5;
  localparam logic [1:0]  SUB_SRAM    = 2'h0;
  localparam logic [1:0]  SUB_FLASHIF = 2'h1;
  localparam logic [1:0]  SUB_BRIDGE0 = 2'h2;
  localparam logic [1:0]  SUB_BRIDGE1 = 2'h3;
  // Flash bank reset values
  localparam logic [31:0] BOOT_ADDR   = 32'h0000_0000;
  localparam logic [31:0] B0_SIZE_RST = 32'h0001_0000;
  localparam logic [31:0] B1_SIZE_RST = 32'h0000_8000;
  localparam logic [1:0]  BANK_EN_RST = 2'h1;
  localparam logic [1:0]  BANK_EN_ALT = 2'h2;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_SRAM, TGT_FLASH0, TGT_FLASH1,
    TGT_FLASHIF, TGT_BRIDGE0, TGT_BRIDGE1, TGT_OTHER
  } caw_tgt_e;
  typedef enum logic [1:0] {SRC_FIFO, SRC_DMA, SRC_CPU} caw_src_e;
  typedef enum logic [1:0] {C_IDLE, C_TCM, C_BUS} caw_cst_e;
endpackage : caw_pkg

// File: design/caw_router.sv
// Purpose: CPU address alias decode with write buffer toward the system bus
// Assumes: Targets answer on the same clock; TCM answers in its request cycle
// Notes:   One system bus engine serves buffer drain, DMA and CPU direct
`timescale 1ns/1ps
module caw_router
  import caw_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        cpu_req,
  input  wire logic        cpu_wr,
  input  wire logic [31:0] cpu_addr,
  input  wire logic [31:0] cpu_wdata,
  output logic             cpu_done_q,
  output logic [31:0]      cpu_rdata_q,
  output logic             cpu_stall_q,
  output logic             tcm_req_q,
  output logic             tcm_wr_q,
  output logic [31:0]      tcm_addr_q,
  output logic [31:0]      tcm_wdata_q,
  input  wire logic [31:0] tcm_rdata,
  input  wire logic        dma_req,
  input  wire logic        dma_wr,
  input  wire logic [31:0] dma_addr,
  input  wire logic [31:0] dma_wdata,
  output logic             dma_done_q,
  output logic [31:0]      dma_rdata_q,
  output logic             sys_req_q,
  output logic             sys_wr_q,
  output caw_tgt_e         sys_tgt_q,
  output logic [31:0]      sys_addr_q,
  output logic [31:0]      sys_wdata_q,
  input  wire logic        sys_ack,
  input  wire logic [31:0] sys_rdata,
  input  wire logic        boot_sel_nv,
  output logic [1:0]       bank_en_q
);

  logic              hready_q;
  logic [31:0]       hrdata_q;
  logic              ahb_pend_q;
  logic              ahb_wr_q;
  logic [7:0]        ahb_off_q;
  logic [31:0]       rd_val;
  logic              wb_en_q;
  logic [1:0]        sram_size_q;
  logic [31:0]       sram_bytes;
  logic [31:0]       bank_base_q [2];
  logic [31:0]       bank_size_q [2];
  logic              boot_s1_q;
  logic              boot_s2_q;
  logic              boot_sel_q;
  logic [31:0]       fifo_addr_q [FIFO_DEPTH];
  logic [31:0]       fifo_data_q [FIFO_DEPTH];
  logic [PTR_W-1:0]  wr_ptr_q;
  logic [PTR_W-1:0]  rd_ptr_q;
  logic [CNT_W-1:0]  count_q;
  logic              fifo_empty;
  logic              fifo_full;
  logic              fifo_push;
  logic              fifo_pop;
  caw_cst_e          cpu_st_q;
  logic              cpu_take;
  logic              cpu_tcm;
  logic              cpu_buf;
  logic              eng_busy_q;
  caw_src_e          eng_src_q;
  logic              grant;
  caw_src_e          pick;
  logic              pick_wr;
  logic [31:0]       pick_addr;
  logic [31:0]       pick_data;
  caw_tgt_e          pick_tgt;
  logic              bus_cpu_done;

  // Flash bank hit against the programmed window
  function automatic logic in_bank(input logic [31:0] a, input int i);
    in_bank = bank_en_q[i] && (a >= bank_base_q[i]) && ((a - bank_base_q[i]) < bank_size_q[i]);
  endfunction : in_bank

  // Target of an address; SRAM offsets past the set size decode to none
  function automatic caw_tgt_e tgt_of(input logic [31:0] a);
    caw_tgt_e t;
    t = TGT_OTHER;
    if (a[31:26] == WIN_TCM)
      t = ({6'h00, a[25:0]} < sram_bytes) ? TGT_SRAM : TGT_NONE;
    else if (a[31:28] == NIB_BUF || a[31:28] == NIB_NBUF)
    begin
      unique case (a[27:26])
        SUB_SRAM:    t = ({6'h00, a[25:0]} < sram_bytes) ? TGT_SRAM : TGT_NONE;
        SUB_FLASHIF: t = TGT_FLASHIF;
        SUB_BRIDGE0: t = TGT_BRIDGE0;
        SUB_BRIDGE1: t = TGT_BRIDGE1;
      endcase
    end
    else if (in_bank(a, 0))
      t = TGT_FLASH0;
    else if (in_bank(a, 1))
      t = TGT_FLASH1;
    tgt_of = t;
  endfunction : tgt_of

  // Address presented to the target
  function automatic logic [31:0] phys_of(input logic [31:0] a, input caw_tgt_e t);
    case (t)
      TGT_SRAM:   phys_of = {6'h00, a[25:0]};
      TGT_FLASH0: phys_of = a - bank_base_q[0];
      TGT_FLASH1: phys_of = a - bank_base_q[1];
      TGT_FLASHIF, TGT_BRIDGE0, TGT_BRIDGE1: phys_of = {NIB_NBUF, a[27:0]};
      default:    phys_of = a;
    endcase
  endfunction : phys_of

  // SRAM size in bytes; an unused code falls back to the largest size
  always_comb
  begin
    case (sram_size_q)
      SRAM_32K: sram_bytes = BYTES_32K;
      SRAM_64K: sram_bytes = BYTES_64K;
      default:  sram_bytes = BYTES_96K;
    endcase
  end

  assign hreadyout = hready_q;
  assign hrdata    = hrdata_q;
  assign hresp     = 1'b0;    // Always OKAY

  // AHB-Lite slave: one wait state so read data leaves a flop
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      hready_q   <= 1'b1;
      hrdata_q   <= 32'h0000_0000;
      ahb_pend_q <= 1'b0;
      ahb_wr_q   <= 1'b0;
      ahb_off_q  <= 8'h00;
    end
    else if (ahb_pend_q)
    begin
      ahb_pend_q <= 1'b0;
      hready_q   <= 1'b1;
      hrdata_q   <= ahb_wr_q ? 32'h0000_0000 : rd_val;
    end
    else if (hsel && htrans[1] && hready)
    begin
      ahb_pend_q <= 1'b1;
      hready_q   <= 1'b0;
      ahb_wr_q   <= hwrite;
      ahb_off_q  <= haddr[7:0];
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    case (ahb_off_q)
      OFF_CTRL:    rd_val[WB_EN_BIT] = wb_en_q;
      OFF_SRAM:    rd_val[1:0] = sram_size_q;
      OFF_B0_BASE: rd_val = bank_base_q[0];
      OFF_B0_SIZE: rd_val = bank_size_q[0];
      OFF_B1_BASE: rd_val = bank_base_q[1];
      OFF_B1_SIZE: rd_val = bank_size_q[1];
      OFF_BANK_EN: rd_val[1:0] = bank_en_q;
      OFF_STATUS:
      begin
        rd_val[ST_STALL]             = cpu_stall_q;
        rd_val[ST_BUSY]              = eng_busy_q;
        rd_val[ST_CNT+CNT_W-1:ST_CNT] = count_q;
        rd_val[ST_BOOT]              = boot_sel_q;
      end
      default:     rd_val = 32'h0000_0000;
    endcase
  end

  // Boot strap pin synchroniser, free running so it is settled in reset
  always_ff @(posedge clk)
  begin
    boot_s1_q <= boot_sel_nv;
    boot_s2_q <= boot_s1_q;
  end

  // Configuration registers; the boot strap is caught only while in reset
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_en_q        <= 1'b0;
      sram_size_q    <= SRAM_32K;
      bank_base_q[0] <= BOOT_ADDR;
      bank_base_q[1] <= BOOT_ADDR;
      bank_size_q[0] <= B0_SIZE_RST;
      bank_size_q[1] <= B1_SIZE_RST;
      bank_en_q      <= boot_s2_q ? BANK_EN_ALT : BANK_EN_RST;
      boot_sel_q     <= boot_s2_q;
    end
    else if (ahb_pend_q && ahb_wr_q)
    begin
      case (ahb_off_q)
        OFF_CTRL:    wb_en_q <= hwdata[WB_EN_BIT];
        OFF_SRAM:    sram_size_q <= hwdata[1:0];
        OFF_B0_BASE: bank_base_q[0] <= hwdata;
        OFF_B0_SIZE: bank_size_q[0] <= hwdata;
        OFF_B1_BASE: bank_base_q[1] <= hwdata;
        OFF_B1_SIZE: bank_size_q[1] <= hwdata;
        OFF_BANK_EN: bank_en_q <= hwdata[1:0];
        default:     ;
      endcase
    end
  end

  // CPU request decode
  assign cpu_take  = cpu_req && !cpu_done_q && (cpu_st_q == C_IDLE);
  assign cpu_tcm   = (cpu_addr[31:26] == WIN_TCM);
  // only enabled writes to the buffered range
  assign cpu_buf   = wb_en_q && cpu_wr && (cpu_addr[31:28] == NIB_BUF);
  assign fifo_empty = (count_q == '0);
  assign fifo_full  = (count_q == CNT_W'(FIFO_DEPTH));
  assign fifo_push  = cpu_take && !cpu_tcm && cpu_buf && !fifo_full;
  assign fifo_pop   = grant && (pick == SRC_FIFO);
  assign bus_cpu_done = eng_busy_q && sys_ack && (eng_src_q == SRC_CPU);

  // Write FIFO storage and pointers
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end
    else
    begin
      if (fifo_push)
      begin
        fifo_addr_q[wr_ptr_q] <= cpu_addr;
        fifo_data_q[wr_ptr_q] <= cpu_wdata;
        wr_ptr_q              <= wr_ptr_q + 1'b1;
      end
      if (fifo_pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      if (fifo_push && !fifo_pop)
        count_q <= count_q + 1'b1;
      else if (fifo_pop && !fifo_push)
        count_q <= count_q - 1'b1;
    end
  end

  // CPU side sequencer
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cpu_st_q    <= C_IDLE;
      cpu_done_q  <= 1'b0;
      cpu_rdata_q <= 32'h0000_0000;
      cpu_stall_q <= 1'b0;
      tcm_req_q   <= 1'b0;
      tcm_wr_q    <= 1'b0;
      tcm_addr_q  <= 32'h0000_0000;
      tcm_wdata_q <= 32'h0000_0000;
    end
    else
    begin
      cpu_done_q <= 1'b0;
      tcm_req_q  <= 1'b0;
      unique case (cpu_st_q)
        C_IDLE:
        begin
          if (cpu_take && cpu_tcm)
          begin
            tcm_req_q   <= 1'b1;
            tcm_wr_q    <= cpu_wr;
            tcm_addr_q  <= {6'h00, cpu_addr[25:0]};
            tcm_wdata_q <= cpu_wdata;
            cpu_stall_q <= 1'b1;
            cpu_st_q    <= C_TCM;
          end
          else if (cpu_take && cpu_buf)
          begin
            // stall while full, retry each cycle
            cpu_done_q  <= !fifo_full;
            cpu_stall_q <= fifo_full;
          end
          else if (cpu_take)
          begin
            cpu_stall_q <= 1'b1;
            cpu_st_q    <= C_BUS;
          end
        end
        C_TCM:
        begin
          cpu_done_q  <= 1'b1;
          cpu_rdata_q <= tcm_rdata;
          cpu_stall_q <= 1'b0;
          cpu_st_q    <= C_IDLE;
        end
        C_BUS:
        begin
          if (bus_cpu_done)
          begin
            cpu_done_q  <= 1'b1;
            cpu_rdata_q <= sys_rdata;
            cpu_stall_q <= 1'b0;
            cpu_st_q    <= C_IDLE;
          end
        end
      endcase
    end
  end

  // Engine arbitration: drain first, so a later direct access sees older writes
  always_comb
  begin
    grant     = 1'b0;
    pick      = SRC_FIFO;
    pick_wr   = 1'b1;
    pick_addr = fifo_addr_q[rd_ptr_q];
    pick_data = fifo_data_q[rd_ptr_q];
    if (!eng_busy_q)
    begin
      if (!fifo_empty)
        grant = 1'b1;
      else if (dma_req && !dma_done_q)
      begin
        grant     = 1'b1;
        pick      = SRC_DMA;
        pick_wr   = dma_wr;
        pick_addr = dma_addr;
        pick_data = dma_wdata;
      end
      else if (cpu_st_q == C_BUS)
      begin
        grant     = 1'b1;
        pick      = SRC_CPU;
        pick_wr   = cpu_wr;
        pick_addr = cpu_addr;
        pick_data = cpu_wdata;
      end
    end
  end
  // Decode in a process so a new SRAM size or bank window re-evaluates at once
  always_comb
  begin
    pick_tgt = tgt_of(pick_addr);
  end

  // System bus engine: request held until the target acknowledges
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      eng_busy_q  <= 1'b0;
      eng_src_q   <= SRC_FIFO;
      sys_req_q   <= 1'b0;
      sys_wr_q    <= 1'b0;
      sys_tgt_q   <= TGT_NONE;
      sys_addr_q  <= 32'h0000_0000;
      sys_wdata_q <= 32'h0000_0000;
    end
    else if (grant)
    begin
      eng_busy_q  <= 1'b1;
      eng_src_q   <= pick;
      sys_req_q   <= 1'b1;
      sys_wr_q    <= pick_wr;
      sys_tgt_q   <= pick_tgt;
      sys_addr_q  <= phys_of(pick_addr, pick_tgt);
      sys_wdata_q <= pick_data;
    end
    else if (eng_busy_q && sys_ack)
    begin
      eng_busy_q <= 1'b0;
      sys_req_q  <= 1'b0;
    end
  end

  // DMA completion pulse with read data
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      dma_done_q  <= 1'b0;
      dma_rdata_q <= 32'h0000_0000;
    end
    else
    begin
      dma_done_q <= eng_busy_q && sys_ack && (eng_src_q == SRC_DMA);
      if (eng_busy_q && sys_ack && (eng_src_q == SRC_DMA))
        dma_rdata_q <= sys_rdata;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_wb_gate: assert property (fifo_push |-> wb_en_q && cpu_wr && cpu_addr[31:28] == NIB_BUF)
    else $error("buffered write without enable or buffered range");
  a_wb_reset: assert property ($past(sys_rst) |-> !wb_en_q)
    else $error("buffer enable set after reset");
  a_buf_done: assert property (fifo_push |=> cpu_done_q && !cpu_stall_q ##1 !cpu_done_q)
    else $error("buffered write not acknowledged next cycle");
  a_full_stall: assert property (cpu_take && cpu_buf && !cpu_tcm && fifo_full |=> cpu_stall_q && !cpu_done_q)
    else $error("full FIFO did not stall CPU");
  a_direct_wait: assert property (cpu_done_q && $past(cpu_st_q) == C_BUS |-> $past(sys_ack))
    else $error("direct access finished before target ack");
  a_read_direct: assert property (cpu_take && !cpu_wr && !cpu_tcm |=> cpu_st_q == C_BUS)
    else $error("read not sent directly");
  a_apb_addr: assert property (sys_req_q && (sys_tgt_q == TGT_BRIDGE0 || sys_tgt_q == TGT_BRIDGE1)
                               |-> sys_addr_q[31:28] == NIB_NBUF)
    else $error("bridge address not folded to window base");
  a_tcm_route: assert property (cpu_take && cpu_tcm |=> tcm_req_q && !(eng_busy_q && eng_src_q == SRC_CPU)
                                ##1 cpu_done_q)
    else $error("coupled window not served by data port");
  a_dma_sram: assert property (grant && pick == SRC_DMA && dma_addr[31:26] == WIN_TCM
                               && dma_addr[25:0] < 26'h000_8000 |=> sys_tgt_q == TGT_SRAM)
    else $error("DMA coupled-window access missed SRAM");
  a_sram_reset: assert property ($past(sys_rst) |-> sram_size_q == SRAM_32K)
    else $error("SRAM size not 32K after reset");
  a_boot_map: assert property ($past(sys_rst) |-> bank_en_q == (boot_sel_q ? BANK_EN_ALT : BANK_EN_RST))
    else $error("boot bank enables wrong after reset");
  a_boot_fixed: assert property (!$past(sys_rst) |-> $stable(boot_sel_q))
    else $error("boot select changed outside reset");
  a_fifo_order: assert property (fifo_pop |=> sys_req_q && sys_wr_q && eng_src_q == SRC_FIFO)
    else $error("FIFO entry not issued as write");

  c_full_stall: cover property (cpu_stall_q && fifo_full);
  c_dma_done: cover property (dma_done_q);
  c_cpu_direct: cover property (bus_cpu_done);

endmodule : caw_router

// File: testbench/caw_sys_target.sv
// Purpose: System bus target model answering after a settable delay
// Assumes: One request at a time, held until acknowledged
// Notes:   Read data is inverted every idle cycle so stale words never pass
`timescale 1ns/1ps
module caw_sys_target (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic [7:0]  dly,
  output logic             ack,
  output logic [31:0]      rdata
);
  logic [31:0] mem [0:63];
  logic [7:0]  cnt_q;
  // Wait dly cycles, then give a one-cycle answer per request
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_q <= 8'h00;
      ack   <= 1'b0;
      rdata <= 32'h0;
      for (int i = 0; i < 64; i++) mem[i] <= 32'h0;
    end
    else if (req && !ack && cnt_q >= dly)
    begin
      ack   <= 1'b1;
      cnt_q <= 8'h00;
      if (wr) mem[addr[7:2]] <= wdata;
      rdata <= wr ? ~rdata : mem[addr[7:2]];
    end
    else
    begin
      ack   <= 1'b0;
      cnt_q <= (req && !ack) ? cnt_q + 8'h01 : 8'h00;
      rdata <= ~rdata;
    end
  end
endmodule : caw_sys_target

// File: testbench/tb_caw_router.sv
// Purpose: Self-checking bench for the address alias router
// Assumes: Slow target stalls the write buffer on purpose
// Notes:   Every system bus answer is logged and checked in order
`timescale 1ns/1ps
module tb_caw_router
  import caw_pkg::*;
;
  logic        clk, sys_rst, hsel, hwrite, cpu_req, cpu_wr, dma_req, dma_wr, boot_sel_nv, sys_ack;
  logic        hreadyout, hresp, cpu_done_q, cpu_stall_q, tcm_req_q, tcm_wr_q, dma_done_q, sys_req_q;
  logic        sys_wr_q, stall_seen;
  logic [1:0]  htrans, bank_en_q;
  logic [2:0]  hsize;
  logic [7:0]  dly;
  logic [31:0] haddr, hwdata, hrdata, cpu_addr, cpu_wdata, cpu_rdata_q, dma_addr, dma_wdata, dma_rdata_q;
  logic [31:0] tcm_addr_q, tcm_wdata_q, tcm_rdata, sys_addr_q, sys_wdata_q, sys_rdata, r;
  caw_tgt_e    sys_tgt_q;
  logic [67:0] log_q[$];
  logic [64:0] tcm_log;
  int          mismatches, comparisons, cycles;
  localparam logic [31:0] DEC_A [5] = '{32'h4800_1234, 32'h5c00_0040, 32'h5400_0008, 32'h5000_0008, 32'h0};
  localparam logic [31:0] DEC_F [5] = '{32'h5800_1234, 32'h5c00_0040, 32'h5400_0008, 32'h8, 32'h0};
  localparam caw_tgt_e    DEC_T [5] = '{TGT_BRIDGE0, TGT_BRIDGE1, TGT_FLASHIF, TGT_SRAM, TGT_FLASH0};

  caw_router caw_router_i (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .cpu_req, .cpu_wr, .cpu_addr, .cpu_wdata,
    .cpu_done_q, .cpu_rdata_q, .cpu_stall_q, .tcm_req_q, .tcm_wr_q, .tcm_addr_q, .tcm_wdata_q,
    .tcm_rdata, .dma_req, .dma_wr, .dma_addr, .dma_wdata, .dma_done_q, .dma_rdata_q, .sys_req_q,
    .sys_wr_q, .sys_tgt_q, .sys_addr_q, .sys_wdata_q, .sys_ack, .sys_rdata, .boot_sel_nv, .bank_en_q);
  caw_sys_target caw_sys_target_i (.clk, .sys_rst, .req(sys_req_q), .wr(sys_wr_q), .addr(sys_addr_q),
    .wdata(sys_wdata_q), .dly, .ack(sys_ack), .rdata(sys_rdata));

  // Coupled memory answers at once with a word derived from the offset
  assign tcm_rdata = tcm_addr_q ^ 32'h5a5a_0000;

  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (sys_req_q && sys_ack) log_q.push_back({sys_wr_q, sys_tgt_q, sys_addr_q, sys_wdata_q});
    if (tcm_req_q) tcm_log = {tcm_wr_q, tcm_addr_q, tcm_wdata_q};
    if (cycles == 20000)
    begin
      mismatches++;
      summarize();
    end
  end

  task summarize;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (exp !== got)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One AHB-Lite single word transfer; read data lands in r
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hreadyout) @(posedge clk);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : ahb

  // CPU or DMA access held until its done pulse; a gap cycle follows
  task acc(input logic dm, input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    if (dm) {dma_req, dma_wr, dma_addr, dma_wdata} <= {1'b1, w, a, d};
    else {cpu_req, cpu_wr, cpu_addr, cpu_wdata} <= {1'b1, w, a, d};
    @(posedge clk);
    while (!(dm ? dma_done_q : cpu_done_q) && n < 300)
    begin
      stall_seen |= cpu_stall_q;
      n++;
      @(posedge clk);
    end
    r = dm ? dma_rdata_q : cpu_rdata_q;
    if (n >= 300) chk("done", 32'h1, 32'h0);
    dma_req <= 1'b0;
    cpu_req <= 1'b0;
    @(posedge clk);
  endtask : acc

  // Next system bus transfer; an address of all ones is not compared
  task chk_log(input logic w, input caw_tgt_e t, input logic [31:0] a);
    int n;
    n = 0;
    while (log_q.size() == 0 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (log_q.size() == 0) chk("log", 32'h1, 32'h0);
    else
    begin
      chk("sys wr", {31'h0, w}, {31'h0, log_q[0][67]});
      chk("sys tgt", {29'h0, t}, {29'h0, log_q[0][66:64]});
      if (a !== 32'hffff_ffff) chk("sys addr", a, log_q[0][63:32]);
      void'(log_q.pop_front());
    end
  endtask : chk_log

  // Main sequence
  initial
  begin
    {hsel, hwrite, cpu_req, cpu_wr, dma_req, dma_wr, boot_sel_nv, stall_seen} = '0;
    {htrans, haddr, hwdata, cpu_addr, cpu_wdata, dma_addr, dma_wdata, dly} = '0;
    hsize = 3'h2;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("bank en", 32'h1, {30'h0, bank_en_q});
    ahb(0, OFF_CTRL, 0); chk("ctrl", 32'h0, r);
    ahb(0, OFF_SRAM, 0); chk("sram size", 32'h0, r);
    ahb(0, OFF_B0_SIZE, 0); chk("bank0 size", B0_SIZE_RST, r);
    ahb(1, OFF_STATUS, 32'hffff_ffff);
    ahb(0, OFF_STATUS, 0); chk("boot", 32'h0, {31'h0, r[ST_BOOT]});
    ahb(0, 8'h40, 0); chk("unmapped", 32'h0, r);
    dly = 8'd5;
    acc(0, 1, 32'h4000_0010, 32'h1111_0000);
    chk("direct wait", 32'h1, log_q.size());
    chk_log(1, TGT_SRAM, 32'h10);
    acc(0, 0, 32'h0400_0020, 0); chk("tcm data", 32'h5a5a_0020, r);
    chk("tcm off bus", 32'h0, log_q.size());
    chk("tcm rd", 32'h0, {31'h0, tcm_log[64]});
    acc(0, 1, 32'h0400_0030, 32'h1234_5678);
    chk("tcm wr", 32'h1, {31'h0, tcm_log[64]});
    chk("tcm addr", 32'h30, tcm_log[63:32]);
    chk("tcm wdata", 32'h1234_5678, tcm_log[31:0]);
    chk("tcm wr off bus", 32'h0, log_q.size());
    ahb(1, OFF_CTRL, 32'h8);
    dly = 8'd20;
    for (int i = 0; i < 6; i++)
    begin
      acc(0, 1, 32'h4000_0100 + 4 * i, i);
      if (i == 0) chk("early done", 32'h0, log_q.size());
    end
    chk("stall", 32'h1, {31'h0, stall_seen});
    for (int i = 0; i < 6; i++) chk_log(1, TGT_SRAM, 32'h100 + 4 * i);
    dly = 8'd2;
    acc(0, 0, 32'h4000_0104, 0); chk("read", 32'h1, r);
    chk_log(0, TGT_SRAM, 32'h104);
    acc(0, 1, 32'h4c00_0010, 0); chk_log(1, TGT_BRIDGE1, 32'h5c00_0010);
    for (int i = 0; i < 5; i++)
    begin
      acc(0, 0, DEC_A[i], 0);
      chk_log(0, DEC_T[i], DEC_F[i]);
    end
    acc(0, 0, 32'h5000_9000, 0); chk_log(0, TGT_NONE, 32'hffff_ffff);
    ahb(1, OFF_SRAM, {30'h0, SRAM_64K});
    acc(0, 0, 32'h5000_9000, 0); chk_log(0, TGT_SRAM, 32'h9000);
    ahb(1, OFF_SRAM, 32'h2);
    acc(0, 0, 32'h5001_0004, 0);
    chk_log(0, TGT_SRAM, 32'h1_0004);
    ahb(1, OFF_B1_BASE, 32'h0001_0000);
    ahb(1, OFF_BANK_EN, 32'h3);
    acc(0, 0, 32'h0001_0004, 0); chk_log(0, TGT_FLASH1, 32'h4);
    acc(1, 1, 32'h4000_0040, 32'h7);
    chk("dma direct", 32'h1, log_q.size());
    chk_log(1, TGT_SRAM, 32'h40);
    acc(1, 0, 32'h0400_0040, 0); chk("dma read", 32'h7, r);
    chk_log(0, TGT_SRAM, 32'h40);
    boot_sel_nv <= 1'b1;
    sys_rst <= 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("alt bank en", {30'h0, BANK_EN_ALT}, {30'h0, bank_en_q});
    acc(0, 0, 32'h0, 0);
    chk_log(0, TGT_FLASH1, 32'h0);
    ahb(0, OFF_STATUS, 0); chk("boot set", 32'h1, {31'h0, r[ST_BOOT]});
    ahb(0, OFF_CTRL, 0); chk("ctrl again", 32'h0, r);
    summarize();
  end
endmodule : tb_caw_router
